// ### cpu_status_flag_register.sv
// status flag register of an 8-bit core
// assumes execution stage and dog timer events on core_clk_i
//
// Behaviour
// - eight bits: signed, chained, expiry, sleep, range, zero, half, carry
// - software writes arithmetic flags only; expiry and sleep read-only
// - carry set on add carry-out or subtract no-borrow; rotate updates it
// - half carry on low nibble carry, or no nibble borrow in subtract
// - zero set when result is zero, cleared otherwise
// - range flag is carry into msb xor carry out of msb
// - signed flag is range flag xor result msb
// - chained copies zero on subtract, ands with zero on borrow subtract
// - sleep cleared by reset or dog restart, set by power-down
// - expiry cleared by reset, restart or power-down, set by timeout
// - flags are never pushed automatically on interrupt or call
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module cpu_status_flag_register (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_b_i,
   input  wire flag_reg_pkg::reg_bus_type  bus_i,
   input  wire flag_reg_pkg::exec_req_type exec_i,
   input  wire logic                       dog_restart_instr_i,
   input  wire logic                       power_down_instr_i,
   input  wire logic                       dog_timeout_i,
   output logic [7:0]                      rdata_o,
   output logic [7:0]                      flags_o
);
   // ----------------------------------------------------------------
   // alu flag computation
   // ----------------------------------------------------------------
   logic [7:0] arith_reg;
   logic       sleep_reg;
   logic       expiry_reg;
   logic [7:0] arith_next;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;
   logic       c_in_msb;
   logic       is_sub;
   logic       cin;
   logic [7:0] bop;
   logic       ov;

   always_comb begin
      is_sub = (exec_i.op == flag_reg_pkg::OP_SUB) ||
               (exec_i.op == flag_reg_pkg::OP_MINUS_BORROW);
      // borrow subtract uses carry as not-borrow
      cin = (exec_i.op == flag_reg_pkg::OP_SUB) ? 1'b1 :
            (exec_i.op == flag_reg_pkg::OP_MINUS_BORROW) ?
            arith_reg[flag_reg_pkg::CARRY_BIT] : 1'b0;
      bop = is_sub ? ~exec_i.b : exec_i.b;
      sum = {1'b0, exec_i.a} + {1'b0, bop} + {8'h00, cin};
      nib = {1'b0, exec_i.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
      c_in_msb = exec_i.a[7] ^ bop[7] ^ sum[7];
      res = (exec_i.op == flag_reg_pkg::OP_LOGIC) ?
            exec_i.logic_result : sum[7:0];
      ov = c_in_msb ^ sum[8];
      arith_next = arith_reg;
      case (exec_i.op)
         flag_reg_pkg::OP_ADD,
         flag_reg_pkg::OP_SUB,
         flag_reg_pkg::OP_MINUS_BORROW: begin
            arith_next[flag_reg_pkg::CARRY_BIT] = sum[8];
            arith_next[flag_reg_pkg::HALF_BIT]  = nib[4];
            arith_next[flag_reg_pkg::ZERO_BIT]  = (res == 8'h00);
            arith_next[flag_reg_pkg::RANGE_BIT] = ov;
            arith_next[flag_reg_pkg::SIGNED_BIT] = ov ^ res[7];
            if (exec_i.op == flag_reg_pkg::OP_SUB) begin
               arith_next[flag_reg_pkg::CHAIN_BIT] = (res == 8'h00);
            end else if (exec_i.op == flag_reg_pkg::OP_MINUS_BORROW) begin
               arith_next[flag_reg_pkg::CHAIN_BIT] =
                  arith_reg[flag_reg_pkg::CHAIN_BIT] & (res == 8'h00);
            end
         end
         flag_reg_pkg::OP_LOGIC: begin
            arith_next[flag_reg_pkg::ZERO_BIT] = (res == 8'h00);
         end
         flag_reg_pkg::OP_ROTATE_CARRY: begin
            arith_next[flag_reg_pkg::CARRY_BIT] = exec_i.rotate_carry;
         end
         default: begin
            arith_next = arith_reg;
         end
      endcase
      if (!exec_i.valid) begin
         arith_next = arith_reg;
      end
      // software write to the arithmetic part
      if (bus_i.wr && bus_i.addr == flag_reg_pkg::FLAG_REG_OFFSET) begin
         arith_next = bus_i.wdata & flag_reg_pkg::WRITE_MASK;
      end
   end

   // ----------------------------------------------------------------
   // arithmetic flags
   // ----------------------------------------------------------------
   // no push on call or interrupt: nothing here saves the flags
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         arith_reg <= flag_reg_pkg::ARITH_RESET;
      end else begin
         arith_reg <= arith_next;
      end
   end

   // ----------------------------------------------------------------
   // system flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         sleep_reg <= flag_reg_pkg::SYS_RESET;
      end else if (dog_restart_instr_i) begin
         sleep_reg <= 1'b0;
      end else if (power_down_instr_i) begin
         sleep_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         expiry_reg <= flag_reg_pkg::SYS_RESET;
      end else if (dog_timeout_i) begin
         expiry_reg <= 1'b1;
      end else if (dog_restart_instr_i || power_down_instr_i) begin
         expiry_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // outputs and read port
   // ----------------------------------------------------------------
   logic [7:0] flags_next;
   always_comb begin
      flags_next = arith_next;
      flags_next[flag_reg_pkg::SLEEP_BIT]  = 1'b0;
      flags_next[flag_reg_pkg::EXPIRY_BIT] = 1'b0;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         flags_o <= flag_reg_pkg::ARITH_RESET;
      end else begin
         flags_o <= flags_next;
         flags_o[flag_reg_pkg::SLEEP_BIT] <= dog_restart_instr_i ? 1'b0 :
            power_down_instr_i ? 1'b1 : sleep_reg;
         flags_o[flag_reg_pkg::EXPIRY_BIT] <= dog_timeout_i ? 1'b1 :
            (dog_restart_instr_i || power_down_instr_i) ? 1'b0 : expiry_reg;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else if (bus_i.rd && bus_i.addr == flag_reg_pkg::FLAG_REG_OFFSET) begin
         rdata_o <= arith_reg | {2'b00, expiry_reg, sleep_reg, 4'h0};
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_WRITE_KEEPS_SYS: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (bus_i.wr && !dog_restart_instr_i && !power_down_instr_i &&
       !dog_timeout_i) |=> $stable(sleep_reg) && $stable(expiry_reg))
      else $error("write changed a system flag");
   AST_WRITE_ARITH: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (bus_i.wr && bus_i.addr == flag_reg_pkg::FLAG_REG_OFFSET) |=>
      arith_reg == ($past(bus_i.wdata) & flag_reg_pkg::WRITE_MASK))
      else $error("write did not land");
   AST_ADD_CARRY: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_ADD && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::CARRY_BIT] ==
      ($past({1'b0, exec_i.a}) + $past({1'b0, exec_i.b}) > 9'h0ff))
      else $error("add carry wrong");
   AST_SUB_HALF: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_SUB && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::HALF_BIT] ==
      ($past(exec_i.a[3:0]) >= $past(exec_i.b[3:0])))
      else $error("sub half carry wrong");
   AST_SUB_ZERO: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_SUB && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::ZERO_BIT] == ($past(exec_i.a) == $past(exec_i.b)))
      else $error("zero flag wrong");
   AST_SIGNED_XOR: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_ADD && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::SIGNED_BIT] ==
      (arith_reg[flag_reg_pkg::RANGE_BIT] ^ $past(sum[7])))
      else $error("signed flag wrong");
   AST_CHAIN_HOLD: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_ADD && !bus_i.wr) |=>
      $stable(arith_reg[flag_reg_pkg::CHAIN_BIT]))
      else $error("chained flag moved");
   AST_SLEEP_SET: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (power_down_instr_i && !dog_restart_instr_i) |=> sleep_reg ##1
      (sleep_reg || $past(dog_restart_instr_i)))
      else $error("sleep flag not set");
   AST_EXPIRY: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      dog_timeout_i |=> expiry_reg)
      else $error("expiry flag not set");
   AST_EXPIRY_CLR: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (power_down_instr_i && !dog_timeout_i) |=> !expiry_reg)
      else $error("expiry flag not cleared");

   AST_READ_SYS: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (bus_i.rd && bus_i.addr == flag_reg_pkg::FLAG_REG_OFFSET) |=>
      rdata_o[flag_reg_pkg::EXPIRY_BIT] == $past(expiry_reg) &&
      rdata_o[flag_reg_pkg::SLEEP_BIT] == $past(sleep_reg))
      else $error("read data system bits wrong");

   AST_READ_UNMAPPED: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (bus_i.rd && bus_i.addr != flag_reg_pkg::FLAG_REG_OFFSET) |=>
      rdata_o == 8'h00)
      else $error("unmapped read not zero");

   AST_READ_IDLE: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      !bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data not zero when idle");

   AST_FLAGS_MATCH: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      flags_o == {arith_reg[7:6], expiry_reg, sleep_reg, arith_reg[3:0]})
      else $error("flag output differs from register");

   AST_WRITE_UNMAPPED: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (bus_i.wr && bus_i.addr != flag_reg_pkg::FLAG_REG_OFFSET &&
       !exec_i.valid) |=>
      $stable(arith_reg))
      else $error("unmapped write changed flags");

   AST_SUB_CARRY: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_SUB && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::CARRY_BIT] ==
      ($past(exec_i.a) >= $past(exec_i.b)))
      else $error("sub carry wrong");

   AST_ROTATE_CARRY: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_ROTATE_CARRY &&
       !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::CARRY_BIT] == $past(exec_i.rotate_carry))
      else $error("rotate carry wrong");

   AST_LOGIC_CARRY: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_LOGIC && !bus_i.wr) |=>
      $stable(arith_reg[flag_reg_pkg::CARRY_BIT]))
      else $error("logic op moved carry");

   AST_ADD_HALF: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_ADD && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::HALF_BIT] ==
      (({1'b0, $past(exec_i.a[3:0])} + {1'b0, $past(exec_i.b[3:0])}) >
       5'h0f))
      else $error("add half carry wrong");

   AST_ADD_ZERO: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_ADD && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::ZERO_BIT] ==
      (($past(exec_i.a) + $past(exec_i.b)) == 8'h00))
      else $error("add zero flag wrong");

   AST_LOGIC_ZERO: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_LOGIC && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::ZERO_BIT] ==
      ($past(exec_i.logic_result) == 8'h00))
      else $error("logic zero flag wrong");

   AST_SUB_CHAIN: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_SUB && !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::CHAIN_BIT] ==
      arith_reg[flag_reg_pkg::ZERO_BIT])
      else $error("chained flag not copied");

   AST_BORROW_CHAIN: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (exec_i.valid && exec_i.op == flag_reg_pkg::OP_MINUS_BORROW &&
       !bus_i.wr) |=>
      arith_reg[flag_reg_pkg::CHAIN_BIT] ==
      ($past(arith_reg[flag_reg_pkg::CHAIN_BIT]) &
       arith_reg[flag_reg_pkg::ZERO_BIT]))
      else $error("chained flag not and-ed");

   AST_SLEEP_CLR: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      dog_restart_instr_i |=> !sleep_reg)
      else $error("sleep flag not cleared");

   AST_SLEEP_HOLD: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (!dog_restart_instr_i && !power_down_instr_i) |=>
      $stable(sleep_reg))
      else $error("sleep flag moved");

   AST_RESET_SYS: assert property (@(posedge core_clk_i)
      !rst_b_i |=> !sleep_reg && !expiry_reg)
      else $error("system flags not reset");

   AST_EXPIRY_HOLD: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (!dog_timeout_i && !dog_restart_instr_i && !power_down_instr_i) |=>
      $stable(expiry_reg))
      else $error("expiry flag moved");

   AST_IDLE_HOLDS: assert property (@(posedge core_clk_i)
      disable iff (!rst_b_i)
      (!exec_i.valid && !bus_i.wr) |=> $stable(arith_reg))
      else $error("flags moved without update");

   // ----------------------------------------------------------------
   // cover properties
   // ----------------------------------------------------------------

   COV_ADD: cover property (@(posedge core_clk_i)
      exec_i.valid && exec_i.op == flag_reg_pkg::OP_ADD);
   COV_BORROW: cover property (@(posedge core_clk_i)
      exec_i.valid && exec_i.op == flag_reg_pkg::OP_MINUS_BORROW);
   COV_TIMEOUT: cover property (@(posedge core_clk_i) dog_timeout_i);
   COV_SLEEP: cover property (@(posedge core_clk_i)
      power_down_instr_i ##1 dog_restart_instr_i);
endmodule : cpu_status_flag_register

// ### exec_core_model.sv
// far-side model: execution stage and dog timer events of the core
// assumes send is called right after a rising edge of the core clock
`timescale 1ns/1ps
module exec_core_model (
   output flag_reg_pkg::exec_req_type exec_o,
   output logic                       restart_o,
   output logic                       sleep_o,
   output logic                       timeout_o
);
   initial begin
      exec_o    = '0;
      restart_o = 1'b0;
      sleep_o   = 1'b0;
      timeout_o = 1'b0;
   end
   // idle operands show the inverse of the last value
   task automatic send(input flag_reg_pkg::exec_req_type r,
                       input logic [2:0] ev);
      flag_reg_pkg::exec_req_type idle;
      idle = ~exec_o;
      idle.valid = 1'b0;
      exec_o <= r.valid ? r : idle;
      {restart_o, sleep_o, timeout_o} <= ev;
   endtask : send
endmodule : exec_core_model

// ### flag_reg_pkg.sv
// package for the cpu status flag register
// assumes a single core clock domain and a plain register port
package flag_reg_pkg;
   // --------------------------------------------------------------
   // bit positions
   // --------------------------------------------------------------
   localparam int CARRY_BIT    = 0;
   localparam int HALF_BIT     = 1;
   localparam int ZERO_BIT     = 2;
   localparam int RANGE_BIT    = 3;
   localparam int SLEEP_BIT    = 4;
   localparam int EXPIRY_BIT   = 5;
   localparam int CHAIN_BIT    = 6;
   localparam int SIGNED_BIT   = 7;
   // --------------------------------------------------------------
   // register map and reset values
   // --------------------------------------------------------------
   localparam logic [3:0] FLAG_REG_OFFSET = 4'h0;
   localparam logic [7:0] WRITE_MASK      = 8'hcf;
   localparam logic [7:0] ARITH_RESET     = 8'h00;
   localparam logic       SYS_RESET       = 1'b0;

   // --------------------------------------------------------------
   // operation classes from the execution stage
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE,
      OP_ADD,
      OP_SUB,
      OP_MINUS_BORROW,
      OP_LOGIC,
      OP_ROTATE_CARRY
   } op_class_type;

   typedef struct packed {
      logic         valid;
      op_class_type op;
      logic [7:0]   a;
      logic [7:0]   b;
      logic [7:0]   logic_result;
      logic         rotate_carry;
   } exec_req_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_bus_type;
endpackage : flag_reg_pkg

// ### tb_top.sv
// bench for the status flag register, reference flags kept in e_reg
// assumes the register at index 0 and read data one cycle after rd
`timescale 1ns/1ps
module tb_top;
   logic                       core_clk_i = 1'b0;
   logic                       rst_b_i    = 1'b0;
   flag_reg_pkg::reg_bus_type  bus        = '0;
   flag_reg_pkg::exec_req_type ex;
   logic                       rs, pd, to, rd_q;
   logic [7:0]                 rdata, flags, e_reg;
   logic [7:0]                 expq[$];
   logic [7:0]                 flq[$];
   int                         failures    = 0;
   int                         comparisons = 0;
   always #2.5 core_clk_i = ~core_clk_i;
   exec_core_model u_core (.exec_o(ex), .restart_o(rs), .sleep_o(pd),
                           .timeout_o(to));
   cpu_status_flag_register u_dut (.core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i), .bus_i(bus), .exec_i(ex),
      .dog_restart_instr_i(rs), .power_down_instr_i(pd),
      .dog_timeout_i(to), .rdata_o(rdata), .flags_o(flags));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // one cycle of stimulus, reference flags updated alongside
   task automatic step(input logic wr, rd, logic [3:0] ad, logic [7:0] wd,
      logic v, flag_reg_pkg::op_class_type op, logic [7:0] a, b,
      logic rc, logic [2:0] ev);
      flag_reg_pkg::exec_req_type r;
      logic [8:0] s;
      logic [7:0] bb, t7, e;
      logic [4:0] t4;
      logic       ci;
      @(posedge core_clk_i);
      bus <= '{wr, rd, ad, wd};
      r = '{v, op, a, b, a, rc};
      u_core.send(r, ev);
      e = e_reg;
      if (rd) expq.push_back(ad == 4'h0 ? e : 8'h00);
      if (v && op inside {flag_reg_pkg::OP_ADD, flag_reg_pkg::OP_SUB,
                          flag_reg_pkg::OP_MINUS_BORROW}) begin
         bb = (op == flag_reg_pkg::OP_ADD) ? b : ~b;
         ci = (op == flag_reg_pkg::OP_ADD) ? 1'b0 :
              (op == flag_reg_pkg::OP_SUB) ? 1'b1 : e_reg[0];
         s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
         t7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
         t4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
         e[0] = s[8];
         e[1] = t4[4];
         e[2] = (s[7:0] == 8'h00);
         e[3] = t7[7] ^ s[8];
         e[7] = e[3] ^ s[7];
         if (op == flag_reg_pkg::OP_SUB) e[6] = e[2];
         if (op == flag_reg_pkg::OP_MINUS_BORROW) e[6] = e_reg[6] & e[2];
      end
      if (v && op == flag_reg_pkg::OP_LOGIC) e[2] = (a == 8'h00);
      if (v && op == flag_reg_pkg::OP_ROTATE_CARRY) e[0] = rc;
      if (wr && ad == 4'h0) e = (wd & flag_reg_pkg::WRITE_MASK) |
                               (e & ~flag_reg_pkg::WRITE_MASK);
      if (ev[2]) e[4] = 1'b0;
      else if (ev[1]) e[4] = 1'b1;
      if (ev[0]) e[5] = 1'b1;
      else if (ev[2] | ev[1]) e[5] = 1'b0;
      e_reg = e;
      if (rd) flq.push_back(e);
   endtask : step
   task automatic wr_rd(input logic [3:0] ad, logic [7:0] wd);
      step(1, 0, ad, wd, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 0);
      step(0, 1, ad, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 0);
   endtask : wr_rd
   task automatic do_reset();
      @(posedge core_clk_i);
      rst_b_i <= 1'b0;
      bus     <= '0;
      u_core.send('0, 3'h0);
      repeat (5) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      e_reg = 8'h00;
   endtask : do_reset
   // ------------------------------------------------------------
   // monitor: compare each read against the oldest note
   // ------------------------------------------------------------
   always @(posedge core_clk_i) rd_q <= bus.rd;
   always @(negedge core_clk_i) begin
      if (rd_q === 1'b1 && expq.size() > 0) begin
         check(rdata, expq[0]);
         if (flq.size() > 0) check(flags, flq[0]);
         void'(expq.pop_front());
         if (flq.size() > 0) void'(flq.pop_front());
      end
   end
   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h46bd59ca));
      do_reset();
      wr_rd(4'h0, 8'hff);
      $display("test write mask done");
      repeat (300) begin
         step(0, 0, 0, 0, $urandom % 4 != 0,
              flag_reg_pkg::op_class_type'($urandom_range(5)),
              $urandom, ($urandom % 3 == 0) ? e_reg : $urandom,
              $urandom, 0);
         if ($urandom % 2) begin
            step(0, 1, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 0);
         end
         if ($urandom % 8 == 0) wr_rd(4'h0, $urandom);
      end
      $display("test arithmetic done");
      for (int i = 0; i < 8; i++) begin
         step(0, 0, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, i[2:0]);
         step(0, 1, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 0);
      end
      step(0, 0, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 3'h2);
      step(0, 0, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 3'h1);
      wr_rd(4'h0, 8'h00);
      wr_rd(4'h5, 8'hff);
      step(0, 1, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 0);
      $display("test system flags done");
      do_reset();
      wr_rd(4'h0, 8'h00);
      step(0, 0, 0, 0, 0, flag_reg_pkg::OP_NONE, 0, 0, 0, 0);
      repeat (2) @(posedge core_clk_i);
      $display("test reset done");
      tally_and_finish();
   end
endmodule : tb_top
